// ===== design/src_pkg.sv
// package for the system reset and clock output block
// assumes a 100 MHz ref_clk and a synchronous active-low reset
package src_pkg;
	// clock rates
	localparam int unsigned SRC_SYS_CLK_MHZ = 100;
	localparam int unsigned SRC_REF_CLK_MHZ = 25;
	localparam int unsigned SRC_REF_DIV = SRC_SYS_CLK_MHZ / SRC_REF_CLK_MHZ;
	localparam int unsigned SRC_REF_DIV_W = 2;
	localparam logic [SRC_REF_DIV_W-1:0] SRC_REF_DIV_LAST = SRC_REF_DIV_W'(SRC_REF_DIV - 1);
	// watchdog pulse width, counted in reference clock periods
	localparam int unsigned SRC_WDOG_PULSE_MS = 200;
	localparam int unsigned SRC_WDOG_TICKS = SRC_WDOG_PULSE_MS * 1000 * SRC_REF_CLK_MHZ;
	localparam int unsigned SRC_WDOG_CNT_W = 23;
	// memory clock pins
	localparam int unsigned SRC_MEM_CLK_PAIRS = 4;
	localparam int unsigned SRC_MEM_CLK_USED = 2;
	// reset values
	localparam logic [1:0] SRC_SYNC_RST = 2'h0;
	localparam logic SRC_MEM_CKE_RST = 1'h0;
	localparam logic SRC_MEM_CLK_RST = 1'h0;

	typedef enum logic {
		SRC_RST_HOLD,
		SRC_RST_RUN
	} src_rst_e;

	typedef enum logic {
		SRC_WD_IDLE,
		SRC_WD_STRETCH
	} src_wd_e;
endpackage

// ===== design/src_wdog_if.sv
// carrier between the sequencer and the watchdog pulse stretcher
// assumes both ends share ref_clk
`timescale 1ns/1ns
interface src_wdog_if;
	logic start;
	logic refTick;
	logic hold;
	logic busy;
	modport seq (output start, output refTick, output hold, input busy);
	modport stretch (input start, input refTick, input hold, output busy);
endinterface

// ===== design/src_wdog_stretch.sv
// watchdog reset pulse stretcher
// assumes refTick pulses once per 25 MHz reference period
`timescale 1ns/1ns
module src_wdog_stretch
	import src_pkg::*;
#(
	parameter int unsigned PULSE_TICKS = SRC_WDOG_TICKS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// link to the sequencer
	src_wdog_if.stretch wd
);
	typedef struct packed {
		src_wd_e state;
		logic [SRC_WDOG_CNT_W-1:0] count;
	} src_wd_s;

	// one extra tick so a partial first period cannot shorten the pulse
	localparam logic [SRC_WDOG_CNT_W-1:0] LAST_TICK = SRC_WDOG_CNT_W'(PULSE_TICKS);

	src_wd_s cur_ff;
	src_wd_s nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		unique case (cur_ff.state)
			SRC_WD_IDLE: begin
				if (wd.start) begin
					nxt_cur.state = SRC_WD_STRETCH;
					nxt_cur.count = '0;
				end
			end
			SRC_WD_STRETCH: begin
				// count reference periods until the width is met [RULE4] [RULE10]
				if (wd.refTick) begin
					if (cur_ff.count == LAST_TICK) begin
						nxt_cur.state = SRC_WD_IDLE;
					end else begin
						nxt_cur.count = cur_ff.count + SRC_WDOG_CNT_W'(1);
					end
				end
			end
		endcase
		if (wd.hold) begin
			nxt_cur.state = SRC_WD_IDLE;
			nxt_cur.count = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_ff <= '{state: SRC_WD_IDLE, count: '0};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign wd.busy = (cur_ff.state == SRC_WD_STRETCH);
endmodule

// ===== design/src_sys_reset_clk.sv
// system reset sequencing and clock output pins
// assumes the board reset pin and other inputs are synchronous enough to ref_clk
`timescale 1ns/1ns
// Function
// RULE1: hold the core and all blocks in reset while the chip reset pin is low
// RULE2: the board keeps the chip reset pin low at least 256 system clocks
// RULE3: during reset every output enable is low, open-drain pins released
// RULE4: a watchdog expiry drives the watchdog reset pin for at least 200 ms
// RULE5: drive a continuous 25 MHz reference clock toward the Ethernet PHY
// RULE6: drive two true and complement memory clock pairs from the system clock
// RULE7: drop the memory clock enable to put the SDRAM into power-down
// RULE8: drive the deskew loop clock out and take its returned copy as feedback
// RULE9: memory clock pairs three and two are reserved and left undriven
// RULE10: stretch the watchdog pulse over 5,000,000 reference clock periods
// RULE11: synchronise the release of the chip reset pin before blocks leave reset
module src_sys_reset_clk
	import src_pkg::*;
#(
	parameter int unsigned WDOG_PULSE_TICKS = SRC_WDOG_TICKS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// board reset pin
	input wire logic chipResetIn_n,
	// internal reset outputs
	output logic coreReset_n,
	output logic blockReset_n,
	// watchdog
	input wire logic wdogExpire,
	output logic watchdogPulseOut,
	output logic watchdogPulseOe,
	// phy reference clock
	output logic phyRefClockOut,
	output logic phyRefClockOe,
	// memory clocks
	output logic [SRC_MEM_CLK_PAIRS-1:0] memDiffClockP,
	output logic [SRC_MEM_CLK_PAIRS-1:0] memDiffClockN,
	output logic [SRC_MEM_CLK_PAIRS-1:0] memDiffClockOe,
	// memory power-down
	input wire logic memPowerDownReq,
	output logic memClockEnableOut,
	output logic memClockEnableOe,
	// deskew loop
	output logic deskewLoopOut,
	output logic deskewLoopOe,
	input wire logic deskewLoopIn,
	output logic deskewFeedback
);
	typedef struct packed {
		logic [1:0] rstSync;
		src_rst_e state;
		logic [SRC_REF_DIV_W-1:0] refDiv;
		logic memClkP;
		logic memClkN;
		logic memCke;
		logic [1:0] fbSync;
	} src_top_s;

	localparam src_top_s TOP_RST = '{
		rstSync: SRC_SYNC_RST,
		state: SRC_RST_HOLD,
		refDiv: '0,
		memClkP: SRC_MEM_CLK_RST,
		memClkN: ~SRC_MEM_CLK_RST,
		memCke: SRC_MEM_CKE_RST,
		fbSync: SRC_SYNC_RST
	};

	src_top_s cur_ff;
	src_top_s nxt_cur;
	src_wdog_if wd ();
	logic running;

	assign running = (cur_ff.state == SRC_RST_RUN);

	always_comb begin
		nxt_cur = cur_ff;
		// two-stage release of the board reset [RULE11]
		nxt_cur.rstSync = {cur_ff.rstSync[0], chipResetIn_n};
		// returned loop clock into a two-stage synchroniser [RULE8]
		nxt_cur.fbSync = {cur_ff.fbSync[0], deskewLoopIn};
		// divide the system clock down to the phy reference [RULE5]
		nxt_cur.refDiv = cur_ff.refDiv + SRC_REF_DIV_W'(1);
		if (cur_ff.refDiv == SRC_REF_DIV_LAST) begin
			nxt_cur.refDiv = '0;
		end
		// memory clock follows the system clock, true and complement [RULE6]
		nxt_cur.memClkP = ~cur_ff.memClkP;
		nxt_cur.memClkN = cur_ff.memClkP;
		// clock enable low while power-down is asked for [RULE7]
		nxt_cur.memCke = ~memPowerDownReq;
		unique case (cur_ff.state)
			SRC_RST_HOLD: begin
				if (cur_ff.rstSync[1]) begin
					nxt_cur.state = SRC_RST_RUN;
				end
			end
			SRC_RST_RUN: begin
				if (!cur_ff.rstSync[1]) begin
					nxt_cur.state = SRC_RST_HOLD;
				end
			end
		endcase
		// everything but the two synchronisers parked while the board holds reset [RULE1]
		if (!cur_ff.rstSync[1]) begin
			nxt_cur.state = SRC_RST_HOLD;
			nxt_cur.refDiv = '0;
			nxt_cur.memClkP = SRC_MEM_CLK_RST;
			nxt_cur.memClkN = ~SRC_MEM_CLK_RST;
			nxt_cur.memCke = SRC_MEM_CKE_RST;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_ff <= TOP_RST;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// watchdog stretcher hookup [RULE4] [RULE10]
	assign wd.start = wdogExpire & running;
	assign wd.refTick = (cur_ff.refDiv == SRC_REF_DIV_LAST);
	assign wd.hold = ~running;

	src_wdog_stretch #(
		.PULSE_TICKS(WDOG_PULSE_TICKS)
	) u_stretch (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wd(wd)
	);

	// internal resets held until the synchronised release [RULE1]
	assign coreReset_n = running;
	assign blockReset_n = running;

	// pin drivers, all enables low in reset [RULE3]
	assign watchdogPulseOut = wd.busy;
	assign watchdogPulseOe = running;
	assign phyRefClockOut = cur_ff.refDiv[SRC_REF_DIV_W-1];
	assign phyRefClockOe = running;
	assign memClockEnableOut = cur_ff.memCke;
	assign memClockEnableOe = running;
	assign deskewLoopOut = cur_ff.memClkP;
	assign deskewLoopOe = running;
	assign deskewFeedback = cur_ff.fbSync[1];

	always_comb begin
		memDiffClockP = '0;
		memDiffClockN = '0;
		memDiffClockOe = '0;
		for (int i = 0; i < SRC_MEM_CLK_USED; i++) begin
			memDiffClockP[i] = cur_ff.memClkP;
			memDiffClockN[i] = cur_ff.memClkN;
			memDiffClockOe[i] = running; // [RULE3] [RULE6]
		end
		// upper pairs stay low and undriven [RULE9]
	end
endmodule

// ===== test/src_board_model.sv
// board reset circuit and deskew loop trace
// assumes resetReq is driven at the falling edge of ref_clk
`timescale 1ns/1ns
module src_board_model (
	// clock and request
	input wire logic ref_clk,
	input wire logic resetReq,
	// loop trace
	input wire logic deskewLoopOut,
	input wire logic deskewLoopOe,
	// pins
	output logic chipResetIn_n,
	output logic deskewLoopIn
);
	int holdCnt = 0;
	logic junk = 1'b0;
	always @(posedge ref_clk) begin
		junk <= ~junk;
		holdCnt <= resetReq ? 256 : (holdCnt != 0 ? holdCnt - 1 : 0);
	end
	assign chipResetIn_n = !(resetReq || holdCnt != 0);
	assign deskewLoopIn = deskewLoopOe ? deskewLoopOut : junk;
endmodule

// ===== test/src_sys_reset_clk_sva.sv
// checker for the reset sequencer and clock pins
// assumes the top module's ports only
`timescale 1ns/1ns
module src_sva
	import src_pkg::*;
#(
	parameter int unsigned WDOG_PULSE_TICKS = SRC_WDOG_TICKS
) (
	// clock, reset, inputs
	input wire logic ref_clk, rst_n, chipResetIn_n, wdogExpire, memPowerDownReq, deskewLoopIn,
	// outputs
	input wire logic coreReset_n, blockReset_n, watchdogPulseOut, watchdogPulseOe,
	input wire logic phyRefClockOut, phyRefClockOe, memClockEnableOut, memClockEnableOe,
	input wire logic deskewLoopOut, deskewLoopOe, deskewFeedback,
	input wire logic [3:0] memDiffClockP, memDiffClockN, memDiffClockOe
);
	int unsigned hiCnt;
	always_ff @(posedge ref_clk) begin
		hiCnt <= (!rst_n || !watchdogPulseOut) ? 0 : hiCnt + 1;
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	AST_HOLD: assert property ($fell(chipResetIn_n) |-> ##3 !coreReset_n && !blockReset_n)
		else $error("blocks not held in reset");
	AST_SYNC: assert property ($rose(chipResetIn_n) |-> !coreReset_n [*3] ##1 coreReset_n)
		else $error("reset release not synchronised");
	AST_TRI: assert property (!coreReset_n |-> memDiffClockOe == 4'h0 && !watchdogPulseOe
		&& !phyRefClockOe && !memClockEnableOe && !deskewLoopOe)
		else $error("pin driven in reset");
	AST_WD_GO: assert property (wdogExpire && coreReset_n && !watchdogPulseOut
		|=> watchdogPulseOut && watchdogPulseOe)
		else $error("watchdog pulse missing");
	AST_WD_LEN: assert property ($fell(watchdogPulseOut) && coreReset_n
		|-> hiCnt >= 4 * WDOG_PULSE_TICKS && hiCnt <= 4 * WDOG_PULSE_TICKS + 4)
		else $error("watchdog pulse width wrong");
	AST_PHY: assert property (phyRefClockOe && $past(phyRefClockOe, 4) |-> phyRefClockOut
		== $past(phyRefClockOut, 4) && phyRefClockOut != $past(phyRefClockOut, 2))
		else $error("reference clock not quarter rate");
	AST_MCLK: assert property (memDiffClockOe[0] && $past(memDiffClockOe[0]) |-> memDiffClockP[1:0]
		== ~$past(memDiffClockP[1:0]) && memDiffClockN[1:0] == ~memDiffClockP[1:0])
		else $error("memory clock pair wrong");
	AST_RSVD: assert property (memDiffClockOe[3:2] == 2'h0 && memDiffClockP[3:2] == 2'h0)
		else $error("reserved pair driven");
	AST_CKE: assert property (coreReset_n && $past(coreReset_n)
		|-> memClockEnableOut == !$past(memPowerDownReq) && memClockEnableOe)
		else $error("clock enable wrong");
	AST_LOOP: assert property (coreReset_n |-> deskewFeedback == $past(deskewLoopIn, 2)
		&& deskewLoopOut == memDiffClockP[0])
		else $error("deskew loop wrong");
	cover property ($rose(watchdogPulseOut));
	cover property ($rose(coreReset_n));
	cover property (coreReset_n && !memClockEnableOut);
endmodule
bind src_sys_reset_clk src_sva #(.WDOG_PULSE_TICKS(WDOG_PULSE_TICKS)) u_sva (.ref_clk, .rst_n,
	.chipResetIn_n, .wdogExpire, .memPowerDownReq, .deskewLoopIn, .coreReset_n, .blockReset_n,
	.watchdogPulseOut, .watchdogPulseOe, .phyRefClockOut, .phyRefClockOe, .memClockEnableOut,
	.memClockEnableOe, .deskewLoopOut, .deskewLoopOe, .deskewFeedback, .memDiffClockP,
	.memDiffClockN, .memDiffClockOe);

// ===== test/testbench.sv
// self-checking bench for the reset sequencer
// assumes the board model on the reset pin and loop trace
`timescale 1ns/1ns
module testbench;
	logic ref_clk = 0, rst_n = 0, resetReq = 1, wdogExpire = 0, memPowerDownReq = 0;
	logic chipResetIn_n, deskewLoopIn, coreReset_n, blockReset_n, watchdogPulseOut;
	logic watchdogPulseOe, phyRefClockOut, phyRefClockOe, memClockEnableOut, memClockEnableOe;
	logic deskewLoopOut, deskewLoopOe, deskewFeedback;
	logic [3:0] memDiffClockP, memDiffClockN, memDiffClockOe;
	int n_errors = 0, num_checks = 0;
	src_sys_reset_clk #(.WDOG_PULSE_TICKS(5)) dut (.ref_clk, .rst_n, .chipResetIn_n, .coreReset_n,
		.blockReset_n, .wdogExpire, .watchdogPulseOut, .watchdogPulseOe, .phyRefClockOut,
		.phyRefClockOe, .memDiffClockP, .memDiffClockN, .memDiffClockOe, .memPowerDownReq,
		.memClockEnableOut, .memClockEnableOe, .deskewLoopOut, .deskewLoopOe, .deskewLoopIn,
		.deskewFeedback);
	src_board_model board (.ref_clk, .resetReq, .deskewLoopOut, .deskewLoopOe, .chipResetIn_n,
		.deskewLoopIn);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_reset();
		int k;
		wdogExpire = 1;
		cyc(1);
		wdogExpire = 0;
		resetReq = 1;
		cyc(1);
		resetReq = 0;
		cyc(255);
		check("rst", 4'h0, {2'h0, coreReset_n, blockReset_n});
		check("oe", 4'h0, memDiffClockOe | {watchdogPulseOe, phyRefClockOe, memClockEnableOe,
			deskewLoopOe});
		k = 0;
		while (coreReset_n !== 1'b1 && k < 300) begin
			cyc(1);
			k++;
		end
		check("release", 4'h4, k[3:0]);
		check("wdcancel", 4'h0, {3'h0, watchdogPulseOut});
	endtask
	task automatic t_clocks();
		logic [7:0] ph;
		logic [1:0] p0;
		logic [1:0] dq;
		for (int i = 0; i < 8; i++) begin
			p0 = memDiffClockP[1:0];
			ph = {ph[6:0], phyRefClockOut};
			dq = {dq[0], deskewLoopIn};
			cyc(1);
			check("mclk", {2'h0, ~p0}, memDiffClockP);
			check("mneg", 4'h3, memDiffClockN ^ memDiffClockP);
			check("moe", 4'h3, memDiffClockOe);
			if (i > 0)
				check("fb", {3'h0, dq[1]}, {3'h0, deskewFeedback});
		end
		check("phy", 4'hF, {ph[7:4] == ph[3:0], 1'b1, ph[0] ^ ph[2], 1'b1});
		check("phy2", 4'h2, 4'($countones(ph[3:0])));
	endtask
	task automatic t_wdog();
		int k;
		wdogExpire = 1;
		cyc(1);
		wdogExpire = 0;
		check("wdo", 4'h3, {2'h0, watchdogPulseOut, watchdogPulseOe});
		k = 0;
		while (watchdogPulseOut === 1'b1 && k < 100) begin
			wdogExpire = (k == 3);
			cyc(1);
			k++;
		end
		check("wlen", 4'h1, {3'h0, k >= 21 && k <= 24});
	endtask
	task automatic t_cke();
		memPowerDownReq = 1;
		cyc(1);
		check("cke0", 4'h1, {2'h0, memClockEnableOut, memClockEnableOe});
		memPowerDownReq = 0;
		cyc(1);
		check("cke1", 4'h3, {2'h0, memClockEnableOut, memClockEnableOe});
	endtask
	initial begin
		cyc(8);
		rst_n = 1;
		t_reset();
		t_clocks();
		t_wdog();
		t_cke();
		t_reset();
		close_out();
	end
	initial begin
		#20000;
		n_errors++;
		close_out();
	end
endmodule
